// ==== rtl/mlh_link.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mlh_regs.svh"

module mlh_link
    import mlh_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // terminal user side
    input  wire logic                        comm_mode,
    input  wire logic                        tx_start,
    input  wire logic [`MLH_FRAME_BITS-1:0]  tx_data,
    output var  logic                        tx_busy,
    output var  logic                        tx_done,
    output var  logic [`MLH_FRAME_BITS-1:0]  rx_data,
    output var  logic                        rx_valid,
    output var  logic                        modem_ready,
    // modem side pins
    input  wire logic                        dsr_pin,
    input  wire logic                        cts_pin,
    input  wire logic                        rlsd_pin,
    input  wire logic                        txclk_pin,
    input  wire logic                        rxclk_pin,
    input  wire logic                        rxd_pin,
    output var  logic                        dtr_pin,
    output var  logic                        rts_pin,
    output var  logic                        txd_pin
);

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic       txclk_old_ff;
    logic       rxclk_old_ff;

    // two stages on every pin; only the second stage is read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff     <= 6'h00;
            sync2_ff     <= 6'h00;
            txclk_old_ff <= 1'b0;
            rxclk_old_ff <= 1'b0;
        end else if (ce) begin
            sync1_ff     <= {dsr_pin, cts_pin, rlsd_pin,
                             txclk_pin, rxclk_pin, rxd_pin};
            sync2_ff     <= sync1_ff;
            txclk_old_ff <= sync2_ff[2];
            rxclk_old_ff <= sync2_ff[1];
        end
    end

    mlh_modem_in_t modem;
    wire logic txclk_s  = sync2_ff[2];
    wire logic rxclk_s  = sync2_ff[1];
    wire logic rxd_s    = sync2_ff[0];
    // bits change on the falling transmit clock edge, the modem
    // samples on the rising one; receive samples on the rising edge
    wire logic txclk_fall = txclk_old_ff & ~txclk_s;
    wire logic rxclk_rise = ~rxclk_old_ff & rxclk_s;

    assign modem.dsr  = sync2_ff[5];
    assign modem.cts  = sync2_ff[4];
    assign modem.rlsd = sync2_ff[3];

    //--------------------------------------------------------------
    // transmit side
    //--------------------------------------------------------------
    mlh_tx_state_t               state_ff;
    mlh_tx_state_t               nxt_state;
    logic [`MLH_FRAME_BITS-1:0]  tx_sh_ff;
    logic [`MLH_CNT_W-1:0]       tx_cnt_ff;
    logic                        done_ff;

    // true on the count of the last bit of a frame; both directions
    // share it so the frame length is decoded in one place only
    function automatic logic at_last(input logic [`MLH_CNT_W-1:0] cnt);
        return cnt == 4'(`MLH_FRAME_BITS - 1);
    endfunction

    // link usable for sending only with terminal and modem both ready
    wire logic link_up  = comm_mode & modem.dsr;
    wire logic last_bit = at_last(tx_cnt_ff);

    // next-state decode
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MLH_TX_IDLE:
                if (tx_start && link_up) begin
                    nxt_state = MLH_TX_WAIT_CTS;
                end
            MLH_TX_WAIT_CTS:
                if (!link_up) begin
                    nxt_state = MLH_TX_IDLE;
                end else if (modem.cts && txclk_fall) begin
                    nxt_state = MLH_TX_SEND;
                end
            MLH_TX_SEND:
                if (!modem.cts || !link_up) begin
                    nxt_state = MLH_TX_DROP;  // lost clear to send aborts
                end else if (txclk_fall && last_bit) begin
                    nxt_state = MLH_TX_DROP;
                end
            MLH_TX_DROP:
                // wait for the modem to drop clear to send, so a
                // stale one never starts the next frame early
                if (!modem.cts) begin
                    nxt_state = MLH_TX_IDLE;
                end
            default:
                nxt_state = MLH_TX_IDLE;
        endcase
    end

    // shift one bit per transmit clock period, lsb first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff  <= MLH_TX_IDLE;
            tx_sh_ff  <= `MLH_SHIFT_RST;
            tx_cnt_ff <= '0;
            done_ff   <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            done_ff  <= (state_ff == MLH_TX_SEND) &&
                        (nxt_state == MLH_TX_DROP);
            if (state_ff == MLH_TX_IDLE && tx_start) begin
                tx_sh_ff  <= tx_data;
                tx_cnt_ff <= '0;
            end else if (state_ff == MLH_TX_SEND && txclk_fall) begin
                tx_sh_ff  <= tx_sh_ff >> 1;
                tx_cnt_ff <= tx_cnt_ff + 4'h1;
            end
        end
    end

    // the bit on the line sits in [0]; on a falling transmit clock
    // inside a frame the register shifts at the same edge, so the
    // next bit is taken one place up to stay in step with it
    wire logic send_now  = (nxt_state == MLH_TX_SEND);
    wire logic shift_now = (state_ff == MLH_TX_SEND) && txclk_fall;
    wire logic nxt_txd   = !send_now ? `MLH_TXD_IDLE :
                           shift_now ? tx_sh_ff[1] : tx_sh_ff[0];

    //--------------------------------------------------------------
    // receive side
    //--------------------------------------------------------------
    logic [`MLH_FRAME_BITS-1:0]  rx_sh_ff;
    logic [`MLH_CNT_W-1:0]       rx_cnt_ff;

    // only listen while carrier is detected and we are not sending;
    // the partial count is flushed when carrier drops
    wire logic rx_en   = modem.rlsd && (state_ff == MLH_TX_IDLE);
    wire logic rx_last = at_last(rx_cnt_ff);

    // the eighth rising receive clock edge completes a frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sh_ff  <= `MLH_SHIFT_RST;
            rx_cnt_ff <= '0;
            rx_data   <= `MLH_SHIFT_RST;
            rx_valid  <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            if (!rx_en) begin
                rx_cnt_ff <= '0;
            end else if (rxclk_rise) begin
                rx_sh_ff  <= {rxd_s, rx_sh_ff[7:1]};
                rx_cnt_ff <= rx_last ? 4'h0 : rx_cnt_ff + 4'h1;
                if (rx_last) begin
                    rx_data  <= {rxd_s, rx_sh_ff[7:1]};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // output registers
    //--------------------------------------------------------------
    // every pin and status output leaves a flop, so no decode glitch
    // reaches the modem cable; the cost is one cycle of latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dtr_pin     <= 1'b0;
            rts_pin     <= 1'b0;
            txd_pin     <= `MLH_TXD_IDLE;
            tx_busy     <= 1'b0;
            tx_done     <= 1'b0;
            modem_ready <= 1'b0;
        end else if (ce) begin
            dtr_pin     <= comm_mode;
            rts_pin     <= (nxt_state == MLH_TX_WAIT_CTS) ||
                           (nxt_state == MLH_TX_SEND);
            txd_pin     <= nxt_txd;
            tx_busy     <= (nxt_state != MLH_TX_IDLE);
            tx_done     <= done_ff;
            modem_ready <= modem.dsr;
        end
    end

endmodule : mlh_link

`default_nettype wire

// ==== rtl/mlh_pkg.sv ====
`default_nettype none

package mlh_pkg;

    // modem control lines coming in, already synchronised
    typedef struct packed {
        logic dsr;
        logic cts;
        logic rlsd;
    } mlh_modem_in_t;

    // transmit-side terminal states
    typedef enum logic [1:0] {
        MLH_TX_IDLE,
        MLH_TX_WAIT_CTS,
        MLH_TX_SEND,
        MLH_TX_DROP
    } mlh_tx_state_t;

endpackage : mlh_pkg

`default_nettype wire

// ==== rtl/mlh_regs.svh ====
`ifndef MLH_REGS_SVH
`define MLH_REGS_SVH

// frame and bit-count sizes
`define MLH_FRAME_BITS   8
`define MLH_CNT_W        4
// idle (mark) level of the transmitted data line
`define MLH_TXD_IDLE     1'b1
// reset value of the shift registers
`define MLH_SHIFT_RST    8'h00

`endif

// ==== verification/mlh_link_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module mlh_link_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // terminal user side
    input wire logic comm_mode,
    input wire logic tx_busy,
    input wire logic tx_done,
    input wire logic rx_valid,
    // modem side pins
    input wire logic cts_pin,
    input wire logic txclk_pin,
    input wire logic dtr_pin,
    input wire logic rts_pin,
    input wire logic txd_pin
);
    default clocking @(posedge clk); endclocking
    // a frozen block is not judged; it resumes where it stopped
    default disable iff (rst || !ce);
    // a link clock fall with the modem still clear; no bit may move yet
    sequence s_fall;
        $fell(txclk_pin) && cts_pin;
    endsequence
    // terminal out of communication mode for a while
    sequence s_cm_off;
        (!comm_mode) [*4];
    endsequence
    // request to send just raised
    sequence s_rts_up;
        $rose(rts_pin);
    endsequence
    // a new data bit while the link is up and clear
    sequence s_bit_go;
        $changed(txd_pin) && rts_pin && cts_pin;
    endsequence
    // ----------------------------------------------------------------
    // control lines, serial line and status outputs
    // ----------------------------------------------------------------
    dtr_follow_a: assert property (comm_mode [*3] |-> dtr_pin)
        else $error("dtr low in comm mode");
    dtr_drop_a: assert property (s_cm_off |-> !dtr_pin && !rts_pin)
        else $error("dtr or rts up out of comm mode");
    rts_cause_a: assert property (s_rts_up |-> dtr_pin && tx_busy)
        else $error("rts rose without dtr or busy");
    idle_line_a: assert property ((!cts_pin) [*6] |-> txd_pin)
        else $error("txd not idle without cts");
    bit_hold_a: assert property (s_fall |-> ##1 $stable(txd_pin) [*2])
        else $error("txd moved too early");
    bit_span_a: assert property (s_bit_go |=> $stable(txd_pin) [*6])
        else $error("txd bit shorter than a link clock period");
    done_idle_a: assert property (tx_done |-> !rts_pin && txd_pin)
        else $error("rts or txd busy at done");
    done_pulse_a: assert property ($rose(tx_done) |=> !tx_done)
        else $error("done longer than a cycle");
    rx_quiet_a: assert property (rx_valid |-> !rts_pin)
        else $error("rx frame while sending");
endmodule // mlh_link_chk

bind mlh_link mlh_link_chk mlh_link_chk_i (.clk(clk), .rst(rst), .ce(ce),
    .comm_mode(comm_mode), .tx_busy(tx_busy), .tx_done(tx_done),
    .rx_valid(rx_valid), .cts_pin(cts_pin), .txclk_pin(txclk_pin),
    .dtr_pin(dtr_pin), .rts_pin(rts_pin), .txd_pin(txd_pin));
`default_nettype wire

// ==== verification/mlh_modem.sv ====
`timescale 1ns/1ns
`default_nettype none
module mlh_modem #(parameter int ECHO = 400) (
    // terminal side
    input  wire logic rts,
    input  wire logic drop,
    input  var  int   dly,
    // modem outputs
    output var  logic dsr,
    output var  logic cts,
    output var  logic rlsd,
    output var  logic txc,
    output var  logic rxc,
    output var  logic rxd
);
    // powered modem keeps data set ready up for good
    initial begin
        dsr = 1'b1;
        {cts, rlsd, txc, rxc, rxd} = 5'h01;
    end
    // carrier starts on request, clear to send only after the delay
    always @(posedge rts) begin
        #(dly + 3); // kept clear of the clock edge
        cts = rts & ~drop;
    end
    always @(negedge rts or posedge drop) cts = 1'b0;
    // transmit clock stands still while no carrier is up
    initial #7 forever #80 txc = rts ? ~txc : 1'b0;
    // far end answers once the echo delay has run out
    task automatic send(input logic [7:0] b);
        wait (!rts);
        #(ECHO);
        rlsd = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            #80 rxc = 1'b1;
            #80 rxc = 1'b0;
        end
        #80 rlsd = 1'b0;
        rxd = ~rxd; // released line shows no stale level
    endtask
endmodule // mlh_modem
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic       clk, rst, cm, go, busy, done, rv, rdy, dsr, cts, rlsd;
    logic       txc, rxc, rxd, dtr, rts, txd, drop, ce;
    logic [7:0] td, rd, got;
    int         dly, mismatches = 0, n_compared = 0;
    mlh_link mlh_link_i (.clk(clk), .rst(rst), .ce(ce), .comm_mode(cm),
        .tx_start(go), .tx_data(td), .tx_busy(busy), .tx_done(done),
        .rx_data(rd), .rx_valid(rv), .modem_ready(rdy), .dsr_pin(dsr),
        .cts_pin(cts), .rlsd_pin(rlsd), .txclk_pin(txc), .rxclk_pin(rxc),
        .rxd_pin(rxd), .dtr_pin(dtr), .rts_pin(rts), .txd_pin(txd));
    mlh_modem mlh_modem_i (.rts(rts), .drop(drop), .dly(dly), .dsr(dsr),
        .cts(cts), .rlsd(rlsd), .txc(txc), .rxc(rxc), .rxd(rxd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // sample mid-bit, 120 ns after the fall that launched it
    always @(negedge txc) begin
        if (rts) begin
            #120;
            if (rts) got = {txd, got[7:1]};
        end
    end
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic chk(input logic [7:0] g, e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_for(ref logic s, input logic v);
        int n = 4000;
        while (s !== v && n > 0) begin
            tick(1);
            n--;
        end
        if (s !== v) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic t_refuse();
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(10);
        chk({dtr, rts}, 2'b00);
        ce = 1'b0;
        cm = 1'b1;
        tick(4);
        chk(dtr, 1'b0);
        ce = 1'b1;
        tick(4);
        chk(dtr, 1'b1);
    endtask
    task automatic t_send(input logic [7:0] b, input int d);
        dly = d;
        td = b;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(2);
        chk({rts, busy}, 2'b11);
        wait_for(done, 1'b1);
        chk(got, b);
        chk({rts, txd}, 2'b01);
        wait_for(busy, 1'b0);
    endtask
    task automatic t_abort();
        td = 8'h00;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_for(cts, 1'b1);
        tick(30);
        drop = 1'b1;
        wait_for(rts, 1'b0);
        tick(10);
        chk({txd, busy, done}, 3'h4);
        drop = 1'b0;
    endtask
    task automatic t_recv(input logic [7:0] b);
        fork
            mlh_modem_i.send(b);
            wait_for(rv, 1'b1);
        join
        chk(rd, b);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {ce, rst, cm, go, drop} = 5'h18;
        {td, dly} = 0;
        tick(6);
        rst = 1'b0;
        t_refuse();
        t_send(8'h96, 100);
        t_recv(8'h3C);
        t_abort();
        t_send(8'h01, 2000);
        t_recv(8'h80);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
